/* File: logic/ips_consts.vh */
`ifndef IPS_CONSTS_VH
`define IPS_CONSTS_VH
// Register byte addresses on the APB window.
`define IPS_PRIO_ADDR 8'hb8
`define IPS_IEN_ADDR 8'ha8
`define IPS_REQ_ADDR 8'hc0
`define IPS_SVC_ADDR 8'hc4
`define IPS_RETI_ADDR 8'hc8
// Priority register field positions.
`define IPS_BIT_EXT0 0
`define IPS_BIT_TMR0 1
`define IPS_BIT_EXT1 2
`define IPS_BIT_TMR1 3
`define IPS_BIT_SER 4
`define IPS_BIT_TMR2 5
`define IPS_BIT_RSVD 6
`define IPS_BIT_STOP 7
// Enable register global bit.
`define IPS_BIT_GLOBAL 7
// Reset values.
`define IPS_PRIO_RST 8'h00
`define IPS_IEN_RST 8'h00
// Number of sources.
`define IPS_NSRC 6
`endif

/* File: logic/ips_level_pick.v */
`timescale 1ns/100ps
// Picks the lowest-numbered source from a request vector, bit 0 first.
module ips_level_pick
(
   // Request vector in.
   input wire [5:0] req,
   // Result out.
   output reg any,
   output reg [2:0] idx
);
   integer i;
   // Scan downward so the lowest index is the last writer and wins.
   always @*
   begin
      any = 1'b0;
      idx = 3'h0;
      for (i = 5; i >= 0; i = i - 1)
      begin
         if (req[i])
         begin
            any = 1'b1;
            idx = i[2:0];
         end
      end
   end
endmodule // ips_level_pick

/* File: logic/ips_core.v */
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "ips_consts.vh"
// What this block does
// - Bits 0-5 map ext0,tmr0,ext1,tmr1,serial,tmr2
// - Bit one means high level, zero low
// - Bit 6 always reads as one
// - Stop bit zero: priority bits are honoured
// - Stop bit one: only enables govern
// - Global enable zero blocks all interrupts
module ips_core
(
   // Clock and reset.
   input wire clk,
   input wire reset_n,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Request lines from the sources, level, already latched upstream.
   input wire [5:0] src_req,
   // Core return-from-service pulse.
   input wire svc_return,
   // Vector request to the core.
   output reg irq_take,
   output reg [2:0] irq_src,
   output reg irq_high
);
   reg [7:0] interrupt_priority_register_r;
   reg [7:0] interrupt_enable_register_r;
   // Service nesting: one slot per level.
   reg in_low_r;
   reg in_high_r;
   reg in_low_nxt;
   reg in_high_nxt;
   wire [5:0] enabled;
   wire [5:0] level_high;
   wire [5:0] req_high;
   wire [5:0] req_low;
   wire any_high;
   wire any_low;
   wire [2:0] idx_high;
   wire [2:0] idx_low;
   wire stop_prio;
   wire setup;
   wire wr;
   wire rd;
   wire ret_wr;
   wire ret;
   reg take_nxt;
   reg [2:0] src_nxt;
   reg high_nxt;
   reg [31:0] rdata_nxt;
   reg err_nxt;

   // Named priority fields.
   wire ext0_level_high = interrupt_priority_register_r[`IPS_BIT_EXT0];
   wire timer0_level_high = interrupt_priority_register_r[`IPS_BIT_TMR0];
   wire ext1_level_high = interrupt_priority_register_r[`IPS_BIT_EXT1];
   wire timer1_level_high = interrupt_priority_register_r[`IPS_BIT_TMR1];
   wire serial_level_high = interrupt_priority_register_r[`IPS_BIT_SER];
   wire timer2_level_high = interrupt_priority_register_r[`IPS_BIT_TMR2];
   wire global_interrupt_enable = interrupt_enable_register_r[`IPS_BIT_GLOBAL];
   assign stop_prio = interrupt_priority_register_r[`IPS_BIT_STOP];

   // Source order follows the register bit order so index equals bit number.
   assign level_high = {timer2_level_high, serial_level_high, timer1_level_high,
                        ext1_level_high, timer0_level_high, ext0_level_high};

   // A source is live only with the global and its own enable set.
   assign enabled = src_req & interrupt_enable_register_r[5:0] & {6{global_interrupt_enable}};

   // With the circuit stopped every source is treated as low level, so no
   // preemption happens and only enables decide service.
   assign req_high = stop_prio ? 6'h00 : (enabled & level_high);
   assign req_low = stop_prio ? enabled : (enabled & ~level_high);

   ips_level_pick u_pick_high
   (
      .req(req_high),
      .any(any_high),
      .idx(idx_high)
   );

   ips_level_pick u_pick_low
   (
      .req(req_low),
      .any(any_low),
      .idx(idx_low)
   );

   // APB decode; every access finishes in its access cycle.
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign ret_wr = wr & (paddr == `IPS_RETI_ADDR);
   assign ret = svc_return | ret_wr;

   // Arbitration and nesting. A high request may enter while only low runs;
   // low requests need both levels idle. Return pops the innermost level.
   always @*
   begin
      in_low_nxt = in_low_r;
      in_high_nxt = in_high_r;
      take_nxt = 1'b0;
      src_nxt = irq_src;
      high_nxt = irq_high;
      if (ret)
      begin
         if (in_high_r)
            in_high_nxt = 1'b0;
         else
            in_low_nxt = 1'b0;
      end
      else if (any_high && !in_high_r)
      begin
         in_high_nxt = 1'b1;
         take_nxt = 1'b1;
         src_nxt = idx_high;
         high_nxt = 1'b1;
      end
      else if (any_low && !in_low_r && !in_high_r)
      begin
         in_low_nxt = 1'b1;
         take_nxt = 1'b1;
         src_nxt = idx_low;
         high_nxt = 1'b0;
      end
   end

   // Read mux; unmapped addresses answer with an error and zero data.
   always @*
   begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         `IPS_PRIO_ADDR:
         begin
            rdata_nxt[7:0] = interrupt_priority_register_r;
            rdata_nxt[`IPS_BIT_RSVD] = 1'b1;
         end
         `IPS_IEN_ADDR:
         begin
            rdata_nxt[7:0] = interrupt_enable_register_r;
            rdata_nxt[6] = 1'b1;
         end
         `IPS_REQ_ADDR:
            rdata_nxt[5:0] = enabled;
         `IPS_SVC_ADDR:
            rdata_nxt[5:0] = {in_high_r, in_low_r, irq_high, irq_src};
         `IPS_RETI_ADDR:
            rdata_nxt = 32'h0000_0000;
         default:
            err_nxt = 1'b1;
      endcase
   end

   // Registers, service state and bus answer.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         interrupt_priority_register_r <= `IPS_PRIO_RST;
         interrupt_enable_register_r <= `IPS_IEN_RST;
         in_low_r <= 1'b0;
         in_high_r <= 1'b0;
         irq_take <= 1'b0;
         irq_src <= 3'h0;
         irq_high <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         in_low_r <= in_low_nxt;
         in_high_r <= in_high_nxt;
         irq_take <= take_nxt;
         irq_src <= src_nxt;
         irq_high <= high_nxt;
         // Ready is raised for the access cycle only: one wait-free answer.
         pready <= setup;
         if (setup)
         begin
            prdata <= rdata_nxt;
            pslverr <= err_nxt;
         end
         else
         begin
            pslverr <= 1'b0;
         end
         // Bit 6 is stored as written but never read back, so it has no effect.
         if (wr && paddr == `IPS_PRIO_ADDR)
            interrupt_priority_register_r <= pwdata[7:0];
         if (wr && paddr == `IPS_IEN_ADDR)
            interrupt_enable_register_r <= pwdata[7:0];
      end
   end
endmodule // ips_core

/* File: test/ips_props.sv */
`timescale 1ns/100ps
module ips_props
(
   // Clock, reset and bus.
   input wire clk, reset_n, psel, penable, pwrite, pready, pslverr,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   // Interrupt side.
   input wire [5:0] src_req,
   input wire svc_return, irq_take, irq_high,
   input wire [2:0] irq_src
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Steps of a bus access and of a high take.
   sequence setup_s; psel && !penable; endsequence
   sequence hi_take_s; irq_take && irq_high && !svc_return; endsequence
   ack_ready_a: assert property (setup_s |=> pready) else $error("no ready after setup");
   err_map_a: assert property (pready |-> pslverr == !(paddr inside {8'hb8, 8'ha8, 8'hc0, 8'hc4, 8'hc8}))
      else $error("bad error flag");
   rsvd_one_a: assert property (pready && !pwrite && paddr == 8'hb8 |-> prdata[6])
      else $error("reserved bit low");
   src_map_a: assert property (irq_take |-> irq_src < 3'h6 && (($past(src_req) >> irq_src) & 6'h1) != 0)
      else $error("take without request");
   take_hold_a: assert property (1'b1 |=> irq_take || $stable({irq_src, irq_high}))
      else $error("source changed");
   high_nest_a: assert property (hi_take_s |=> !irq_take) else $error("high preempted");
   low_nest_a: assert property (irq_take && !irq_high && !svc_return |=> !irq_take || irq_high)
      else $error("low preempted low");
endmodule // ips_props
bind ips_core ips_props u_props (.*);

/* File: test/ips_cpu.sv */
`timescale 1ns/100ps
module ips_cpu
(
   // Clock and reset.
   input wire clk, reset_n,
   // Take in, return out.
   input wire irq_take,
   input wire [3:0] dly,
   output logic svc_return
);
   logic [3:0] cnt_r;
   // A nested take restarts the count, so only the inner routine returns.
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         cnt_r <= 0;
         svc_return <= 0;
      end
      else
      begin
         svc_return <= cnt_r == 1;
         cnt_r <= irq_take ? dly : cnt_r - (cnt_r != 0);
      end
endmodule // ips_cpu

/* File: test/ips_core_tb.sv */
`timescale 1ns/100ps
module ips_core_tb;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, irq_take, irq_high, svc_return;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, lfsr = 32'h64c0e06c;
   logic [5:0] src_req = 0;
   logic [2:0] irq_src;
   logic [3:0] dly = 2;
   logic [8:0] q[$];
   integer n_fail = 0, n_tests = 0, i;
   ips_core DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_req(src_req), .svc_return(svc_return), .irq_take(irq_take), .irq_src(irq_src), .irq_high(irq_high));
   ips_cpu CPU (.clk(clk), .reset_n(reset_n), .irq_take(irq_take), .dly(dly), .svc_return(svc_return));
   // Clock.
   initial forever #10 clk = ~clk;
   task end_sim;
      begin
         $display("checks %0d errors %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [8:0] v, e);
      begin
         n_tests++;
         if (v !== e)
         begin
            $display("[ERR] %s exp %h got %h", nm, e, v);
            n_fail++;
         end
      end
   endtask
   // Next value of the stimulus shift register.
   function logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // An empty queue yields a value no result can match.
   function logic [8:0] pop;
      pop = q.size() ? q.pop_front() : 9'h1ff;
   endfunction
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer k;
      begin
         psel <= 1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1;
         k = 0;
         do @(posedge clk); while (!pready && ++k < 20);
         psel <= 0;
         penable <= 0;
         @(posedge clk);
         if (k == 20)
         begin
            n_fail++;
            end_sim;
         end
      end
   endtask
   // The top bit of the note is the expected error flag.
   task rd(input logic [7:0] a, input logic [8:0] e);
      begin
         q.push_back(e);
         apb(0, a, 0);
      end
   endtask
   // Waits for a take, then drops the requests and waits six cycles, enough for a short routine to return.
   task wt;
      integer k;
      begin
         k = 0;
         do @(posedge clk); while (!irq_take && ++k < 40);
         src_req <= 0;
         if (k == 40)
         begin
            n_fail++;
            end_sim;
         end
         repeat (6) @(posedge clk);
      end
   endtask
   // Compares each read and each take against the oldest note.
   always @(posedge clk)
   begin
      if (psel && penable && pready && !pwrite)
         chk("rd", {pslverr, prdata[7:0]}, pop());
      if (irq_take)
         chk("irq", {5'h10, irq_high, irq_src}, pop());
   end
   initial
   begin
      repeat (5) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      rd(8'hb8, 9'h040);
      apb(1, 8'hb8, 32'h2a);
      rd(8'hb8, 9'h06a);
      rd(8'h10, 9'h100);
      apb(1, 8'ha8, 32'hbf);
      $display("registers done");
      // The one high source beats random low ones.
      for (i = 0; i < 6; i++)
      begin
         lfsr = lfsr_next(lfsr);
         apb(1, 8'hb8, 32'h1 << i);
         q.push_back({6'h21, i[2:0]});
         src_req <= lfsr[5:0] | 6'h1 << i;
         wt;
      end
      $display("levels done");
      apb(1, 8'hb8, 32'ha0);
      q.push_back(9'h102);
      src_req <= 6'h24;
      wt;
      apb(1, 8'ha8, 32'h3f);
      rd(8'ha8, 9'h07f);
      src_req <= 6'h3f;
      repeat (10) @(posedge clk);
      q.push_back(9'h100);
      apb(1, 8'ha8, 32'hbf);
      wt;
      $display("stop and global done");
      // A slow low routine is preempted by a high request.
      apb(1, 8'hb8, 32'h01);
      dly <= 15;
      q.push_back(9'h101);
      src_req <= 6'h02;
      wt;
      q.push_back(9'h108);
      src_req <= 6'h03;
      wt;
      repeat (20) @(posedge clk);
      // Low routine still open, high one returned, last take was high source 0.
      rd(8'hc4, 9'h018);
      // A waiting low request is visible but not taken while low runs.
      src_req <= 6'h02;
      rd(8'hc0, 9'h002);
      src_req <= 0;
      apb(1, 8'hc8, 0);
      rd(8'hc4, 9'h008);
      chk("left", q.size(), 0);
      $display("preempt done");
      end_sim;
   end
endmodule // ips_core_tb
